/* ptd_pkg.sv */
/*
  Package for the pulse train and delay output channel: register map,
  field positions, reset values, modes, states and timing constants.
  Assumes a 20 MHz system clock and a simple strobed register port.
*/
package ptd_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TB_1MS_US = 1000;
  localparam int unsigned TB_01MS_US = 100;
  localparam int unsigned TB_1MS_CYC = CLK_HZ / 1_000_000 * TB_1MS_US;
  localparam int unsigned TB_01MS_CYC = CLK_HZ / 1_000_000 * TB_01MS_US;
  // Register width and address width
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  // Register offsets (word index)
  localparam logic [3:0] REG_DATA = 4'h0;    // Pulse count or off-delay
  localparam logic [3:0] REG_CTRL = 4'h1;    // Control byte
  localparam logic [3:0] REG_FACTOR = 4'h2;  // Period factor, steps of 0.1
  localparam logic [3:0] REG_CFG = 4'h3;     // Mode and options
  localparam logic [3:0] REG_ONDLY = 4'h4;   // On-delay
  localparam logic [3:0] REG_MINPW = 4'h5;   // Minimum pulse duration
  localparam logic [3:0] REG_PERIOD = 4'h6;  // Period
  localparam logic [3:0] REG_STATUS = 4'h7;  // Channel status
  localparam logic [3:0] REG_IRQ_STS = 4'h8; // Sticky events
  localparam logic [3:0] REG_IRQ_MSK = 4'h9; // Event mask
  // Control byte fields
  localparam int unsigned CTRL_SW_EN = 0;
  // Configuration fields
  localparam int unsigned CFG_MODE = 0;      // 0 pulse train, 1 on/off-delay
  localparam int unsigned CFG_TB = 1;        // 0 1 ms, 1 0.1 ms
  localparam int unsigned CFG_HWGATE = 2;    // Gate input acts as hardware gate
  localparam int unsigned CFG_GRPDIAG = 3;   // Group diagnostics enable
  localparam int unsigned CFG_OUTDIAG = 4;   // Output diagnostics enable
  localparam int unsigned CFG_STOPOFF = 5;   // Output off on controller stop
  // Status fields
  localparam int unsigned STS_EN = 0;
  localparam int unsigned STS_OUT = 1;
  localparam int unsigned STS_SC_OUT = 2;
  localparam int unsigned STS_SC_SUP = 3;
  // Event bits
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_DIAG = 1;
  localparam int unsigned EV_W = 2;
  // Reset values
  localparam logic [15:0] CFG_RST = 16'h0038;
  localparam logic [7:0] FACTOR_RST = 8'h0A;
  localparam logic [7:0] FACTOR_UNITY = 8'h0A;
  // Channel states
  typedef enum logic [4:0] {
    PTD_IDLE = 5'b00001,
    PTD_WAIT = 5'b00010,
    PTD_HIGH = 5'b00100,
    PTD_LOW = 5'b01000,
    PTD_OFFD = 5'b10000
  } ptd_state_t;
endpackage

/* ptd_sync.sv */
/*
  Three-flop input synchroniser with agreement filter.
  Assumes the input is asynchronous to i_clock.
*/
`timescale 1ns/1ps
module ptd_sync (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Pin and result
  input wire logic i_async,
  output logic o_level
);
  typedef struct packed {
    logic [2:0] sh;
    logic lvl;
  } ptd_sync_st_t;
  ptd_sync_st_t s_reg, s_next;

  // Shift; the filtered level changes only when stages two and three agree
  always_comb begin
    s_next = s_reg;
    s_next.sh = {s_reg.sh[1:0], i_async};
    if (s_reg.sh[1] == s_reg.sh[2]) begin
      s_next.lvl = s_reg.sh[2];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_level = s_reg.lvl;
endmodule

/* ptd_tick.sv */
/*
  Time base divider: one-cycle tick every 1 ms or every 0.1 ms.
  Assumes a 20 MHz clock; restarts when the base selection changes.
*/
`timescale 1ns/1ps
module ptd_tick
  import ptd_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Base select and tick
  input wire logic i_fine,
  output logic o_tick
);
  localparam int unsigned CW = $clog2(TB_1MS_CYC);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic fine;
  } ptd_tick_st_t;
  ptd_tick_st_t s_reg, s_next;
  logic [CW-1:0] s_top;

  // Count down from the selected length
  always_comb begin
    s_top = i_fine ? CW'(TB_01MS_CYC - 1) : CW'(TB_1MS_CYC - 1);
    s_next = s_reg;
    s_next.fine = i_fine;
    if (s_reg.fine != i_fine || s_reg.cnt == '0) begin
      s_next.cnt = s_top;
    end else begin
      s_next.cnt = s_reg.cnt - CW'(1);
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_tick = (s_reg.cnt == '0) && (s_reg.fine == i_fine);
endmodule

/* ptd_channel.sv */
/*
  One pulse output channel: pulse-train and on/off-delay modes, time base,
  diagnostics, controller-stop response, registers and interrupt.
  Assumes a register master on i_clock with one-cycle strobes; pins async.
*/
// The register offsets and the address-and-strobe port were left to the implementer.
// Behaviour
// - All durations count in units of the selected time base.
// - Pulse train: high for minimum pulse duration, low for period minus it.
// - With hardware gate and software enable set, rising gate starts the train.
// - Zero on-delay drives the output with no added delay.
// - Group diagnostics report encoder supply short; output short is gated by output diagnostics.
// - Output diagnostics detect a short on the control output.
// - When configured, controller stop forces the control output off.
// - On/off-delay: output follows the gate, on while gate stays asserted.
// - On/off-delay: output turns on after the on-delay from gate assertion.
// - On/off-delay: output turns off after the full off-delay.
// - On/off-delay ignores minimum pulse duration and period.
// - Output state flag reports the control output.
// - Enable status flag clears after the preset pulses are out.
`timescale 1ns/1ps
module ptd_channel
  import ptd_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register port
  input wire logic [ptd_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ptd_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [ptd_pkg::DATA_W-1:0] o_rdata,
  // Pins
  input wire logic i_gate_input,
  input wire logic i_out_short,
  input wire logic i_supply_short,
  input wire logic i_ctrl_stop,
  output logic o_control_out,
  // Interrupt and diagnostics
  output logic o_irq,
  output logic o_diag
);
  initial begin
    if (CNT_W < 8 || CNT_W > 32) begin
      $error("CNT_W out of range");
    end
  end

  typedef struct packed {
    ptd_state_t st;
    logic [15:0] data;
    logic [7:0] ctrl;
    logic [7:0] factor;
    logic [15:0] cfg;
    logic [15:0] ondly;
    logic [15:0] minpw;
    logic [15:0] period;
    logic [CNT_W-1:0] tcnt;
    logic [15:0] pulses;
    logic en_sts;
    logic out;
    logic gate_d;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] msk;
    logic [15:0] rdata;
  } ptd_st_t;
  ptd_st_t s_reg, s_next;

  logic s_gate;
  logic s_osc;
  logic s_ssc;
  logic s_stop;
  logic s_tick;
  logic s_sw_en;
  logic s_odm;
  logic s_hwg;
  logic s_gate_rise;
  logic s_out_sc;
  logic s_sup_sc;
  logic [CNT_W+7:0] s_scaled;
  logic [CNT_W-1:0] s_low_len;
  logic [EV_W-1:0] s_ev_set;

  // Synchronise every pin input
  ptd_sync u_sync_gate (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_async(i_gate_input), .o_level(s_gate));
  ptd_sync u_sync_osc (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_async(i_out_short), .o_level(s_osc));
  ptd_sync u_sync_ssc (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_async(i_supply_short), .o_level(s_ssc));
  ptd_sync u_sync_stop (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_async(i_ctrl_stop), .o_level(s_stop));

  // Time base tick
  ptd_tick u_tick (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_fine(s_reg.cfg[CFG_TB]),
    .o_tick(s_tick)
  );

  // Register decode used by the write paths; the read path decodes i_addr in its own case
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    return a == off;
  endfunction

  // Widen a duration to the counter width
  function automatic logic [CNT_W-1:0] wid(input logic [15:0] v);
    return CNT_W'(v);
  endfunction

  // Derived control terms
  always_comb begin
    s_sw_en = s_reg.ctrl[CTRL_SW_EN];
    s_odm = s_reg.cfg[CFG_MODE];
    s_hwg = s_reg.cfg[CFG_HWGATE];
    s_gate_rise = s_gate && !s_reg.gate_d;
    s_out_sc = s_osc && s_reg.cfg[CFG_OUTDIAG];
    s_sup_sc = s_ssc && s_reg.cfg[CFG_GRPDIAG];
    // Period scaled by factor / 10, low time is period less high time
    s_scaled = CNT_W'(s_reg.period) * s_reg.factor / FACTOR_UNITY;
    if (s_scaled[CNT_W-1:0] > wid(s_reg.minpw)) begin
      s_low_len = s_scaled[CNT_W-1:0] - wid(s_reg.minpw);
    end else begin
      s_low_len = '0;
    end
  end

  // Next state of the whole channel
  always_comb begin
    s_next = s_reg;
    s_ev_set = '0;
    s_next.gate_d = s_gate;
    // Register writes
    if (i_wr) begin
      if (hit(i_addr, REG_DATA)) s_next.data = i_wdata;
      if (hit(i_addr, REG_CTRL)) s_next.ctrl = i_wdata[7:0];
      if (hit(i_addr, REG_FACTOR)) s_next.factor = i_wdata[7:0];
      if (hit(i_addr, REG_CFG)) s_next.cfg = i_wdata;
      if (hit(i_addr, REG_ONDLY)) s_next.ondly = i_wdata;
      if (hit(i_addr, REG_MINPW)) s_next.minpw = i_wdata;
      if (hit(i_addr, REG_PERIOD)) s_next.period = i_wdata;
      if (hit(i_addr, REG_IRQ_MSK)) s_next.msk = i_wdata[EV_W-1:0];
    end
    // Sequencer; time counters step on the base tick
    case (s_reg.st)
      PTD_IDLE: begin
        s_next.out = 1'b0;
        if (s_sw_en && !s_reg.ctrl[CTRL_SW_EN] == 1'b0) begin
          if (s_odm) begin
            if (s_gate) begin
              s_next.tcnt = wid(s_reg.ondly);
              if (s_reg.ondly == '0) begin
                s_next.out = 1'b1;
                s_next.st = PTD_HIGH;
              end else begin
                s_next.st = PTD_WAIT;
              end
            end
          end else if (s_reg.en_sts && (!s_hwg || s_gate_rise)) begin
            s_next.pulses = s_reg.data;
            s_next.tcnt = wid(s_reg.ondly);
            if (s_reg.data == '0) begin
              s_next.en_sts = 1'b0;
              s_ev_set[EV_DONE] = 1'b1;
            end else if (s_reg.ondly == '0) begin
              s_next.out = 1'b1;
              s_next.tcnt = wid(s_reg.minpw);
              s_next.st = PTD_HIGH;
            end else begin
              s_next.st = PTD_WAIT;
            end
          end
        end
      end
      PTD_WAIT: begin
        if (s_odm && !s_gate) begin
          s_next.st = PTD_IDLE;
        end else if (s_tick) begin
          if (s_reg.tcnt <= CNT_W'(1)) begin
            s_next.out = 1'b1;
            s_next.tcnt = wid(s_reg.minpw);
            s_next.st = PTD_HIGH;
          end else begin
            s_next.tcnt = s_reg.tcnt - CNT_W'(1);
          end
        end
      end
      PTD_HIGH: begin
        if (s_odm) begin
          // Pulse parameters play no part here
          if (!s_gate) begin
            s_next.tcnt = wid(s_reg.data);
            if (s_reg.data == '0) begin
              s_next.out = 1'b0;
              s_next.st = PTD_IDLE;
            end else begin
              s_next.st = PTD_OFFD;
            end
          end
        end else if (s_tick) begin
          if (s_reg.tcnt <= CNT_W'(1)) begin
            s_next.out = 1'b0;
            s_next.pulses = s_reg.pulses - 16'h0001;
            s_next.tcnt = s_low_len;
            s_next.st = PTD_LOW;
          end else begin
            s_next.tcnt = s_reg.tcnt - CNT_W'(1);
          end
        end
      end
      PTD_LOW: begin
        if (s_reg.pulses == '0) begin
          s_next.en_sts = 1'b0;
          s_ev_set[EV_DONE] = 1'b1;
          s_next.st = PTD_IDLE;
        end else if (s_tick || s_reg.tcnt == '0) begin
          if (s_reg.tcnt <= CNT_W'(1)) begin
            s_next.out = 1'b1;
            s_next.tcnt = wid(s_reg.minpw);
            s_next.st = PTD_HIGH;
          end else begin
            s_next.tcnt = s_reg.tcnt - CNT_W'(1);
          end
        end
      end
      PTD_OFFD: begin
        if (s_gate) begin
          s_next.st = PTD_HIGH;
        end else if (s_tick) begin
          if (s_reg.tcnt <= CNT_W'(1)) begin
            s_next.out = 1'b0;
            s_ev_set[EV_DONE] = 1'b1;
            s_next.st = PTD_IDLE;
          end else begin
            s_next.tcnt = s_reg.tcnt - CNT_W'(1);
          end
        end
      end
      default: begin
        s_next.st = PTD_IDLE;
        s_next.out = 1'b0;
      end
    endcase
    // Abort on software enable clear, or on controller stop when stop-off is configured
    if (!s_sw_en || (s_stop && s_reg.cfg[CFG_STOPOFF])) begin
      s_next.out = 1'b0;
      s_next.st = PTD_IDLE;
      s_next.en_sts = s_sw_en && s_reg.en_sts && !s_stop;
    end
    // Enable status follows a fresh software enable; placed after the abort
    // so that the write that sets the enable is not undone by the old value
    if (i_wr && hit(i_addr, REG_CTRL) && i_wdata[CTRL_SW_EN] && !s_sw_en) begin
      s_next.en_sts = 1'b1;
    end
    if (s_out_sc) begin
      s_next.out = 1'b0;
    end
    // Sticky events: set wins over write-one-to-clear
    s_ev_set[EV_DIAG] = s_out_sc || s_sup_sc;
    if (i_wr && hit(i_addr, REG_IRQ_STS)) begin
      s_next.ev = s_reg.ev & ~i_wdata[EV_W-1:0];
    end
    s_next.ev = s_next.ev | s_ev_set;
    // Read data registered for the next cycle
    s_next.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        REG_DATA: s_next.rdata = s_reg.data;
        REG_CTRL: s_next.rdata = {8'h00, s_reg.ctrl};
        REG_FACTOR: s_next.rdata = {8'h00, s_reg.factor};
        REG_CFG: s_next.rdata = s_reg.cfg;
        REG_ONDLY: s_next.rdata = s_reg.ondly;
        REG_MINPW: s_next.rdata = s_reg.minpw;
        REG_PERIOD: s_next.rdata = s_reg.period;
        REG_STATUS: begin
          s_next.rdata[STS_EN] = s_reg.en_sts;
          s_next.rdata[STS_OUT] = s_reg.out;
          s_next.rdata[STS_SC_OUT] = s_out_sc;
          s_next.rdata[STS_SC_SUP] = s_sup_sc;
        end
        REG_IRQ_STS: s_next.rdata = {{(16-EV_W){1'b0}}, s_reg.ev};
        REG_IRQ_MSK: s_next.rdata = {{(16-EV_W){1'b0}}, s_reg.msk};
        default: s_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
      s_reg.st <= PTD_IDLE;
      s_reg.cfg <= CFG_RST;
      s_reg.factor <= FACTOR_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign o_control_out = s_reg.out;
  assign o_rdata = s_reg.rdata;
  assign o_irq = |(s_reg.ev & s_reg.msk);
  assign o_diag = s_reg.ev[EV_DIAG];
endmodule

/* ptd_channel_properties.sv */
/*
  Concurrent checks on the ports of the pulse train and delay channel.
  Assumes bind to ptd_channel; shadows of config, mask and enable come from bus writes.
*/
`timescale 1ns/1ps
module ptd_channel_properties
  import ptd_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register port
  input wire logic [ptd_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ptd_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [ptd_pkg::DATA_W-1:0] o_rdata,
  // Pins
  input wire logic i_gate_input,
  input wire logic i_out_short,
  input wire logic i_supply_short,
  input wire logic i_ctrl_stop,
  input wire logic o_control_out,
  // Interrupt and diagnostics
  input wire logic o_irq,
  input wire logic o_diag
);
  logic [15:0] cfg_reg, msk_reg;
  logic sw_reg;
  logic [3:0] stop_reg, short_reg, sup_reg, off_reg;
  function automatic logic [3:0] sat(input logic [3:0] c, input logic en);
    return en ? ((c == 4'hF) ? c : c + 4'h1) : 4'h0;
  endfunction
  // Shadow registers and level-hold counters
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_reg <= CFG_RST;
      msk_reg <= 16'h0000;
      sw_reg <= 1'b0;
      stop_reg <= 4'h0;
      short_reg <= 4'h0;
      sup_reg <= 4'h0;
      off_reg <= 4'h0;
    end else begin
      if (i_wr && i_addr == REG_CFG) cfg_reg <= i_wdata;
      if (i_wr && i_addr == REG_IRQ_MSK) msk_reg <= i_wdata;
      if (i_wr && i_addr == REG_CTRL) sw_reg <= i_wdata[CTRL_SW_EN];
      stop_reg <= sat(stop_reg, i_ctrl_stop);
      short_reg <= sat(short_reg, i_out_short);
      sup_reg <= sat(sup_reg, i_supply_short);
      off_reg <= sat(off_reg, !sw_reg);
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside its slot");
  AST_RD_UNMAP: assert property ($past(i_rd) && $past(i_addr) > REG_IRQ_MSK |-> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_STOP_OFF: assert property (cfg_reg[CFG_STOPOFF] && stop_reg > 4'h7 |-> !o_control_out)
    else $error("output on during controller stop");
  AST_SHORT_OFF: assert property (cfg_reg[CFG_OUTDIAG] && short_reg > 4'h7 |-> !o_control_out)
    else $error("output on during output short");
  AST_SUP_DIAG: assert property (cfg_reg[CFG_GRPDIAG] && sup_reg > 4'h7 |-> o_diag)
    else $error("supply short not reported");
  AST_SW_OFF: assert property (off_reg > 4'h2 |-> !o_control_out)
    else $error("output on without software enable");
  AST_ROSE_EN: assert property ($rose(o_control_out) |-> sw_reg)
    else $error("output rose while enable clear");
  AST_IRQ_MASK: assert property (msk_reg == 16'h0000 && $past(msk_reg) == 16'h0000 |-> !o_irq)
    else $error("interrupt with all events masked");
  AST_DIAG_IRQ: assert property (o_diag && msk_reg[EV_DIAG] && $past(msk_reg[EV_DIAG]) |-> o_irq)
    else $error("unmasked diagnostic without interrupt");
  AST_STS_OUT: assert property ($past(i_rd && i_addr == REG_STATUS && o_control_out) && o_control_out
    |-> o_rdata[STS_OUT])
    else $error("output state flag wrong");
endmodule
bind ptd_channel ptd_channel_properties #(.CNT_W(CNT_W)) i_ptd_channel_properties (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_gate_input(i_gate_input), .i_out_short(i_out_short),
  .i_supply_short(i_supply_short), .i_ctrl_stop(i_ctrl_stop), .o_control_out(o_control_out),
  .o_irq(o_irq), .o_diag(o_diag));

/* ptd_ctrl_model.sv */
/*
  Controller model: strobed register master writing control and data words.
  Assumes the channel never stalls and read data stand one cycle after the strobe.
*/
`timescale 1ns/1ps
module ptd_ctrl_model
  import ptd_pkg::*;
(
  // Clock
  input wire logic i_clock,
  // Register port toward the channel
  output logic [ptd_pkg::ADDR_W-1:0] o_addr,
  output logic [ptd_pkg::DATA_W-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [ptd_pkg::DATA_W-1:0] i_rdata
);
  // Idle bus at time zero
  initial begin
    o_addr = 4'h0;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // One-cycle write; released lines are scrambled, not left at the last value
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clock);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    // Let the write settle in the channel before the caller looks
    @(negedge i_clock);
  endtask
  // One-cycle read; data taken in the following cycle only
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clock);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clock);
    d = i_rdata;
  endtask
endmodule

/* ptd_channel_tb.sv */
/*
  Self-checking bench for the channel: registers, pulse train, delay mode, faults.
  Assumes the controller model and the 0.1 ms base to keep the run short.
*/
`timescale 1ns/1ps
module ptd_channel_tb;
  import ptd_pkg::*;
  localparam int T = TB_01MS_CYC;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic gate = 1'b0, oshort = 1'b0, sshort = 1'b0, stop = 1'b0, lv = 1'b0;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, d;
  logic wr, rd, out, irq, diag;
  int err_total = 0, n_compared = 0, run = 0, n, m, p, c;
  int hq[$], lq[$];
  always #25 i_clock = ~i_clock;
  ptd_ctrl_model i_ptd_ctrl_model (.i_clock(i_clock), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
  ptd_channel i_ptd_channel (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_gate_input(gate),
    .i_out_short(oshort), .i_supply_short(sshort), .i_ctrl_stop(stop),
    .o_control_out(out), .o_irq(irq), .o_diag(diag));
  // Model side: record high and low run lengths of the output
  always @(posedge i_clock) begin
    if (out !== lv) begin
      if (lv) hq.push_back(run);
      else lq.push_back(run);
      run = 1;
      lv = out;
    end else run++;
  end
  task w(input logic [3:0] a, input logic [15:0] x);
    i_ptd_ctrl_model.wr(a, x);
  endtask
  task r(input logic [3:0] a, output logic [15:0] x);
    i_ptd_ctrl_model.rd(a, x);
  endtask
  task chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  // Timer boundaries may slip by one tick plus synchroniser delay
  function automatic logic near(int a, int e);
    return a >= e - T - 8 && a <= e + T + 8;
  endfunction
  task wt(input int k);
    repeat (k) @(posedge i_clock);
  endtask
  task til(input logic v, input int lim, output int k);
    k = 0;
    while (out !== v && k < lim) begin
      @(negedge i_clock);
      k++;
    end
  endtask
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    wt(100000);
    err_total++;
    finish_test;
  end
  // Main sequence
  initial begin
    void'($urandom(38897));
    wt(20);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 12; a++) begin
      r(a[3:0], d);
      chk(d === (a == 3 ? CFG_RST : a == 2 ? {8'h00, FACTOR_RST} : 16'h0000), "reset value");
    end
    w(4'hC, 16'hFFFF);
    r(4'hC, d);
    chk(d === 16'h0000, "unmapped read");
    $display("test registers done");
    n = 1 + $urandom % 3;
    m = 1 + $urandom % 2;
    p = m + 1 + $urandom % 2;
    w(REG_DATA, 16'(n));
    w(REG_FACTOR, {8'h00, FACTOR_UNITY});
    w(REG_ONDLY, 16'h0000);
    w(REG_MINPW, 16'(m));
    w(REG_PERIOD, 16'(p));
    w(REG_CFG, 16'h003E);
    w(REG_IRQ_MSK, 16'h0001);
    hq.delete();
    lq.delete();
    w(REG_CTRL, 16'h0001);
    wt(2 * T);
    chk(hq.size() == 0 && out === 1'b0, "train ran without gate");
    gate <= 1'b1;
    til(1'b1, 20, c);
    chk(c <= 8, "late start at zero on-delay");
    c = 0;
    while (irq !== 1'b1 && c < (n * p + 2) * T) begin
      @(negedge i_clock);
      c++;
    end
    wt(4);
    chk(hq.size() == n, "pulse count");
    foreach (hq[i]) chk(near(hq[i], m * T), "high time");
    for (int i = 1; i < lq.size(); i++) chk(near(lq[i], (p * 10 / 10 - m) * T), "low time");
    r(REG_STATUS, d);
    chk(d[STS_EN] === 1'b0 && d[STS_OUT] === 1'b0, "enable flag after train");
    w(REG_IRQ_STS, 16'h0001);
    chk(irq === 1'b0, "done event not cleared");
    gate <= 1'b0;
    w(REG_CTRL, 16'h0000);
    $display("test pulse train done");
    n = 1 + $urandom % 3;
    m = 1 + $urandom % 3;
    w(REG_CFG, 16'h003F);
    w(REG_DATA, 16'(m));
    w(REG_ONDLY, 16'(n));
    w(REG_MINPW, 16'($urandom % 8));
    w(REG_PERIOD, 16'($urandom % 8));
    w(REG_CTRL, 16'h0001);
    hq.delete();
    gate <= 1'b1;
    til(1'b1, (n + 2) * T, c);
    chk(near(c, n * T), "on-delay");
    wt(2 * T);
    chk(hq.size() == 0 && out === 1'b1, "output dropped with gate high");
    r(REG_STATUS, d);
    chk(d[STS_OUT] === 1'b1, "state flag high");
    gate <= 1'b0;
    til(1'b0, (m + 2) * T, c);
    chk(near(c, m * T), "off-delay");
    r(REG_STATUS, d);
    chk(d[STS_OUT] === 1'b0, "state flag low");
    w(REG_CTRL, 16'h0000);
    w(REG_IRQ_STS, 16'h0003);
    $display("test delay mode done");
    w(REG_CFG, 16'h003A);
    w(REG_DATA, 16'h0064);
    w(REG_MINPW, 16'h0001);
    w(REG_PERIOD, 16'h0002);
    w(REG_IRQ_MSK, 16'h0000);
    w(REG_CTRL, 16'h0001);
    til(1'b1, 3 * T, c);
    stop <= 1'b1;
    wt(T);
    chk(out === 1'b0, "output on in controller stop");
    stop <= 1'b0;
    w(REG_CTRL, 16'h0000);
    w(REG_CTRL, 16'h0001);
    til(1'b1, 3 * T, c);
    w(REG_CTRL, 16'h0000);
    wt(2 * T);
    chk(out === 1'b0, "output on after enable cleared");
    w(REG_CTRL, 16'h0001);
    til(1'b1, 3 * T, c);
    oshort <= 1'b1;
    wt(10);
    chk(out === 1'b0 && diag === 1'b1, "output short");
    oshort <= 1'b0;
    w(REG_CTRL, 16'h0000);
    r(REG_IRQ_STS, d);
    chk(d[EV_DIAG] === 1'b1, "diag event");
    w(REG_IRQ_MSK, 16'h0002);
    chk(irq === 1'b1, "diag interrupt");
    w(REG_IRQ_STS, 16'h0002);
    chk(diag === 1'b0 && irq === 1'b0, "diag clear");
    sshort <= 1'b1;
    wt(10);
    chk(diag === 1'b1 && irq === 1'b1, "supply short");
    sshort <= 1'b0;
    w(REG_IRQ_STS, 16'h0002);
    $display("test faults done");
    finish_test;
  end
endmodule
